// >>> hw/qgt_pkg.sv
/*
  Constants for the four-timer unit: APB register map, field positions, reset values.
  Assumes a 32-bit APB master and a 40 MHz system clock.
*/
package qgt_pkg;
  localparam int unsigned NUM_TIMERS = 4;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned PRESC_DIV  = 16;
  localparam logic [3:0]  PRESC_LAST = 4'hF;
  // Per-timer block of four words at 0x10 * index
  localparam logic [11:0] TMR_STRIDE = 12'h010;
  localparam logic [11:0] OFS_CFG    = 12'h000;
  localparam logic [11:0] OFS_REF    = 12'h004;
  localparam logic [11:0] OFS_CNT    = 12'h008;
  localparam logic [11:0] OFS_CAP    = 12'h00C;
  localparam logic [11:0] OFS_STAT   = 12'h040;
  localparam logic [11:0] OFS_GCFG   = 12'h044;
  // Timer configuration fields
  localparam int unsigned CFG_EN     = 0;
  localparam int unsigned CFG_SRC_LO = 1;
  localparam int unsigned CFG_GATE   = 3;
  localparam int unsigned CFG_TOGGLE = 4;
  localparam int unsigned CFG_CE_LO  = 5;
  localparam int unsigned CFG_RESTART = 7;
  localparam int unsigned CFG_W      = 8;
  // Global configuration bits named cascade 1->2 and 3->4; only stored and read back
  localparam int unsigned GCFG_CAS12 = 0;
  localparam int unsigned GCFG_CAS34 = 1;
  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [15:0] REF_RST    = 16'hFFFF;
  // Count sources
  localparam logic [1:0] SRC_TIMER = 2'h0;
  localparam logic [1:0] SRC_SYS   = 2'h1;
  localparam logic [1:0] SRC_DIV16 = 2'h2;
  localparam logic [1:0] SRC_PIN   = 2'h3;
  // Capture edge modes
  localparam logic [1:0] CE_OFF  = 2'h0;
  localparam logic [1:0] CE_RISE = 2'h1;
  localparam logic [1:0] CE_FALL = 2'h2;
  localparam logic [1:0] CE_BOTH = 2'h3;
endpackage

// >>> hw/quad_gated_timer_unit.sv
/*
  Four 16-bit timers with gate, source select, capture, match outputs and cascading.
  Assumes an APB master on CLK_I; all pin inputs are asynchronous and synchronised here.
*/
// The APB interface to the registers and the register offsets were left to the implementer.
// Functional notes
// - Gate input pauses the timer when gating enabled; its rising edge restarts it.
// - First gate input serves timer 1, timer 2, or both, per configuration.
// - Second gate input serves timer 3, timer 4, or both; only two gates.
// - Each timer drives its own output pin when count reaches reference.
// - Per timer, match output is an active-low pulse or a toggle.
// - A timer's match can count the next timer, forming a 32-bit counter.
// - Count source: other timer, system clock, clock divided by sixteen, input pin.
// - Four external timer input pins at most.
// - Count captured on input pin rising, falling, or both edges.
module quad_gated_timer_unit #(
  parameter int unsigned N = qgt_pkg::NUM_TIMERS
) (
  input  wire logic          CLK_I,
  input  wire logic          RST_N_I,
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire logic [11:0]   PADDR_I,
  input  wire logic [31:0]   PWDATA_I,
  output logic      [31:0]   PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  input  wire logic          GATE_IN_A_I,
  input  wire logic          GATE_IN_B_I,
  input  wire logic [N-1:0]  CAPTURE_IN_I,
  output logic      [N-1:0]  MATCH_OUT_PINS_O
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0]   gate_a_sync_q, gate_b_sync_q;
  logic [N-1:0] cap_s1_q, cap_s2_q, cap_s3_q;
  logic [1:0]   gate_prev_q;
  logic [3:0]   presc_q;
  logic         div16_tick;
  logic [qgt_pkg::CFG_W-1:0] cfg_q [N];
  logic [15:0]  ref_q [N];
  logic [15:0]  cnt_q [N];
  logic [15:0]  cap_q [N];
  logic [N-1:0] match_flag_q, cap_flag_q;
  logic [N-1:0] out_q;
  logic [1:0]   gcfg_q;
  logic [N-1:0] tick, hit, cap_ev, gate_open, restart;
  logic         wr_en;
  logic [31:0]  rdata_d;

  assign wr_en      = PSEL_I & PENABLE_I & PWRITE_I;
  assign PREADY_O   = 1'b1;
  assign div16_tick = (presc_q == qgt_pkg::PRESC_LAST);

  function automatic logic is_addr(input logic [11:0] a, input int unsigned t, input logic [11:0] ofs);
    is_addr = (a == 12'((t * 32'(qgt_pkg::TMR_STRIDE)) + 32'(ofs)));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; third stage only feeds edge detection.
  // Not reset: they track the pins during reset, so no false edge follows its release
  always_ff @(posedge CLK_I)
  begin
    gate_a_sync_q <= {gate_a_sync_q[0], GATE_IN_A_I};
    gate_b_sync_q <= {gate_b_sync_q[0], GATE_IN_B_I};
    cap_s1_q      <= CAPTURE_IN_I;
    cap_s2_q      <= cap_s1_q;
    cap_s3_q      <= cap_s2_q;
    gate_prev_q   <= {gate_b_sync_q[1], gate_a_sync_q[1]};
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      presc_q <= 4'h0;
    else
      presc_q <= presc_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-timer datapath
  for (genvar t = 0; t < N; t++)
  begin : g_tmr
    logic gsig, grise, prev_hit, pin_rise, pin_fall;
    logic [1:0] src, ce;
    assign gsig     = (t < 2) ? gate_a_sync_q[1] : gate_b_sync_q[1];
    assign grise    = gsig & ~((t < 2) ? gate_prev_q[0] : gate_prev_q[1]);
    assign gate_open[t] = ~cfg_q[t][qgt_pkg::CFG_GATE] | gsig;
    assign restart[t]   = cfg_q[t][qgt_pkg::CFG_GATE] & cfg_q[t][qgt_pkg::CFG_RESTART] & grise;
    assign prev_hit = (t == 0) ? 1'b0 : hit[(t == 0) ? 0 : t-1];
    assign pin_rise = cap_s2_q[t] & ~cap_s3_q[t];
    assign pin_fall = ~cap_s2_q[t] & cap_s3_q[t];
    assign src      = cfg_q[t][qgt_pkg::CFG_SRC_LO +: 2];
    assign ce       = cfg_q[t][qgt_pkg::CFG_CE_LO +: 2];

    always_comb
    begin
      unique case (src)
        qgt_pkg::SRC_TIMER: tick[t] = prev_hit;
        qgt_pkg::SRC_SYS:   tick[t] = 1'b1;
        qgt_pkg::SRC_DIV16: tick[t] = div16_tick;
        qgt_pkg::SRC_PIN:   tick[t] = pin_rise;
      endcase
    end

    assign hit[t] = cfg_q[t][qgt_pkg::CFG_EN] & gate_open[t] & tick[t] & (cnt_q[t] == ref_q[t]);
    assign cap_ev[t] = ((ce == qgt_pkg::CE_RISE) & pin_rise) | ((ce == qgt_pkg::CE_FALL) & pin_fall)
                     | ((ce == qgt_pkg::CE_BOTH) & (pin_rise | pin_fall));

    always_ff @(posedge CLK_I)
    begin
      if (!RST_N_I)
        cnt_q[t] <= 16'h0000;
      else if (wr_en && is_addr(PADDR_I, t, qgt_pkg::OFS_CNT))
        cnt_q[t] <= PWDATA_I[15:0];
      else if (restart[t] || hit[t])
        cnt_q[t] <= 16'h0000;
      else if (cfg_q[t][qgt_pkg::CFG_EN] && gate_open[t] && tick[t])
        cnt_q[t] <= cnt_q[t] + 16'h0001;
    end

    always_ff @(posedge CLK_I)
    begin
      if (!RST_N_I)
        cap_q[t] <= 16'h0000;
      else if (cap_ev[t])
        cap_q[t] <= cnt_q[t];
    end

    always_ff @(posedge CLK_I)
    begin
      if (!RST_N_I)
        out_q[t] <= 1'b1;
      else if (cfg_q[t][qgt_pkg::CFG_TOGGLE])
        out_q[t] <= hit[t] ? ~out_q[t] : out_q[t];
      else
        out_q[t] <= ~hit[t];
    end

    always_ff @(posedge CLK_I)
    begin
      if (!RST_N_I)
      begin
        cfg_q[t] <= qgt_pkg::CFG_RST;
        ref_q[t] <= qgt_pkg::REF_RST;
      end
      else if (wr_en)
      begin
        if (is_addr(PADDR_I, t, qgt_pkg::OFS_CFG))
          cfg_q[t] <= PWDATA_I[qgt_pkg::CFG_W-1:0];
        if (is_addr(PADDR_I, t, qgt_pkg::OFS_REF))
          ref_q[t] <= PWDATA_I[15:0];
      end
    end

    always_ff @(posedge CLK_I)
    begin
      if (!RST_N_I)
      begin
        match_flag_q[t] <= 1'b0;
        cap_flag_q[t]   <= 1'b0;
      end
      else
      begin
        // Hardware set wins over a simultaneous write-one clear
        if (hit[t])
          match_flag_q[t] <= 1'b1;
        else if (wr_en && PADDR_I == qgt_pkg::OFS_STAT && PWDATA_I[t])
          match_flag_q[t] <= 1'b0;
        if (cap_ev[t])
          cap_flag_q[t] <= 1'b1;
        else if (wr_en && PADDR_I == qgt_pkg::OFS_STAT && PWDATA_I[8+t])
          cap_flag_q[t] <= 1'b0;
      end
    end
  end

  assign MATCH_OUT_PINS_O = out_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Cascade enable bits are only stored and read back; no timer's source selection uses them
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      gcfg_q <= 2'h0;
    else if (wr_en && PADDR_I == qgt_pkg::OFS_GCFG)
      gcfg_q <= PWDATA_I[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB read mux; zero-wait, unmapped reads zero with PSLVERR
  always_comb
  begin
    rdata_d   = 32'h0000_0000;
    PSLVERR_O = PSEL_I & PENABLE_I;
    for (int t = 0; t < N; t++)
    begin
      if (is_addr(PADDR_I, t, qgt_pkg::OFS_CFG))
      begin
        rdata_d   = {24'h000000, cfg_q[t]};
        PSLVERR_O = 1'b0;
      end
      if (is_addr(PADDR_I, t, qgt_pkg::OFS_REF))
      begin
        rdata_d   = {16'h0000, ref_q[t]};
        PSLVERR_O = 1'b0;
      end
      if (is_addr(PADDR_I, t, qgt_pkg::OFS_CNT))
      begin
        rdata_d   = {16'h0000, cnt_q[t]};
        PSLVERR_O = 1'b0;
      end
      if (is_addr(PADDR_I, t, qgt_pkg::OFS_CAP))
      begin
        rdata_d   = {16'h0000, cap_q[t]};
        PSLVERR_O = 1'b0;
      end
    end
    if (PADDR_I == qgt_pkg::OFS_STAT)
    begin
      rdata_d   = {20'h00000, cap_flag_q, 4'h0, match_flag_q};
      PSLVERR_O = 1'b0;
    end
    if (PADDR_I == qgt_pkg::OFS_GCFG)
    begin
      rdata_d   = {30'h0, gcfg_q};
      PSLVERR_O = 1'b0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      PRDATA_O <= 32'h0000_0000;
    else if (PSEL_I && !PENABLE_I)
      PRDATA_O <= rdata_d;
  end

endmodule

// >>> bench/qgt_sva.sv
/* Port checker for quad_gated_timer_unit.
   Sees only the top ports; bound at the foot. */
module qgt_sva #(
  parameter int unsigned N = 4
) (
  input wire logic         CLK_I,
  input wire logic         RST_N_I,
  input wire logic         PSEL_I,
  input wire logic         PENABLE_I,
  input wire logic         PWRITE_I,
  input wire logic [11:0]  PADDR_I,
  input wire logic [31:0]  PWDATA_I,
  input wire logic [31:0]  PRDATA_O,
  input wire logic         PREADY_O,
  input wire logic         PSLVERR_O,
  input wire logic         GATE_IN_A_I,
  input wire logic         GATE_IN_B_I,
  input wire logic [N-1:0] CAPTURE_IN_I,
  input wire logic [N-1:0] MATCH_OUT_PINS_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  logic acc;
  logic rdm;
  assign acc = PSEL_I && PENABLE_I;
  assign rdm = acc && !PWRITE_I && PADDR_I[1:0] == 2'h0;
  ////////////////////////////////////////
  a_ready_high: assert property (PREADY_O)
    else $error("pready low");
  a_err_idle: assert property (!PENABLE_I |-> !PSLVERR_O)
    else $error("slverr outside access");
  a_err_hole: assert property (acc && PADDR_I == 12'h048 |-> PSLVERR_O)
    else $error("no slverr on hole");
  a_err_mapped: assert property (rdm && PADDR_I < 12'h048 |-> !PSLVERR_O)
    else $error("slverr on register");
  a_rd_hold: assert property (acc |=> $stable(PRDATA_O))
    else $error("read data moved");
  a_reg_upper: assert property (rdm && PADDR_I < 12'h040 |-> PRDATA_O[31:16] == 16'h0000)
    else $error("upper bits set");
  a_stat_bits: assert property (rdm && PADDR_I == 12'h040 |-> (PRDATA_O & 32'hFFFFF0F0) == 32'h0)
    else $error("status spare bits set");
  a_rst_idle: assert property (disable iff (1'h0) !RST_N_I |=> &MATCH_OUT_PINS_O && PRDATA_O == 32'h0)
    else $error("outputs not idle in reset");
endmodule

bind quad_gated_timer_unit qgt_sva #(.N(N)) qgt_sva_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .GATE_IN_A_I(GATE_IN_A_I), .GATE_IN_B_I(GATE_IN_B_I),
  .CAPTURE_IN_I(CAPTURE_IN_I), .MATCH_OUT_PINS_O(MATCH_OUT_PINS_O));

// >>> bench/qgt_pins.sv
/* Board-side model: gate and timer-input pins, match-pin counters.
   Pins follow the bench's requests one clock edge later.
   Counts low cycles of match pins 0 and 2 and level changes of pins 1 and 3. */
module qgt_pins (
  input  wire logic       clk_i,
  input  wire logic       ga_req_i,
  input  wire logic       gb_req_i,
  input  wire logic [3:0] cap_req_i,
  input  wire logic [3:0] match_i,
  output logic            gate_in_a_o,
  output logic            gate_in_b_o,
  output logic [3:0]      cap_o,
  output int              lows_o = 0,
  output int              flips_o = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] prev_q = 4'hF;
  always @(posedge clk_i)
  begin
    gate_in_a_o <= ga_req_i;
    gate_in_b_o <= gb_req_i;
    cap_o       <= cap_req_i;
    lows_o      <= lows_o + int'(match_i[0] === 1'h0) + int'(match_i[2] === 1'h0);
    flips_o     <= flips_o + int'(match_i[1] !== prev_q[1]) + int'(match_i[3] !== prev_q[3]);
    prev_q      <= match_i;
  end
endmodule

// >>> bench/tb_top.sv
/* Self-checking bench for quad_gated_timer_unit.
   APB master tasks and a pin model; 40 MHz clock. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, pready, ga, gb;
  logic        ga_req = 1'h1, gb_req = 1'h1;
  logic [3:0]  cap, mo, cap_req = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0000762C;
  int          lows, flips, l0, f0, r, num_errors = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  quad_gated_timer_unit quad_gated_timer_unit_i (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(),
    .GATE_IN_A_I(ga), .GATE_IN_B_I(gb), .CAPTURE_IN_I(cap), .MATCH_OUT_PINS_O(mo));
  qgt_pins qgt_pins_i (.clk_i(clk), .ga_req_i(ga_req), .gb_req_i(gb_req), .cap_req_i(cap_req), .match_i(mo),
    .gate_in_a_o(ga), .gate_in_b_o(gb), .cap_o(cap), .lows_o(lows), .flips_o(flips));
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Matches seen in a run of counting edges, one match per period
  function automatic logic [31:0] exp_hits(input int cyc, input int per);
    return cyc / per;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    chk({31'h0, g >= lo && g <= hi}, 32'h1);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #200us;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    rdc(12'h000, 32'h0);
    rdc(12'h034, 32'h0000FFFF);
    rdc(12'h048, 32'h0);
    r = 3 + int'(xs() % 8);
    apb(1'h1, 12'h004, r);
    apb(1'h1, 12'h014, r);
    apb(1'h1, 12'h000, 32'h03);
    apb(1'h1, 12'h010, 32'h13);
    l0 = lows;
    f0 = flips;
    repeat (20 * (r + 1)) @(posedge clk);
    rng(lows - l0, 19, 21);
    rng(flips - f0, 19, 21);
    apb(1'h1, 12'h000, 32'h0);
    apb(1'h1, 12'h010, 32'h0);
    apb(1'h0, 12'h040, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'h1, 12'h040, 32'hF);
    rdc(12'h040, 32'h0);
    apb(1'h1, 12'h014, 32'hFFFF);
    apb(1'h1, 12'h008, 32'h0);
    apb(1'h1, 12'h018, 32'h0);
    apb(1'h1, 12'h010, 32'h01);
    apb(1'h1, 12'h000, 32'h03);
    repeat (5 * (r + 1) + (r + 1) / 2 - 2) @(posedge clk);
    apb(1'h1, 12'h000, 32'h0);
    rdc(12'h018, exp_hits(5 * (r + 1) + (r + 1) / 2 + 1, r + 1));
    apb(1'h1, 12'h020, 32'h05);
    repeat (160) @(posedge clk);
    apb(1'h0, 12'h028, 32'h0);
    rng(rd, 9, 11);
    ga_req <= 1'h0;
    apb(1'h1, 12'h000, 32'h8B);
    apb(1'h1, 12'h020, 32'h8B);
    apb(1'h1, 12'h008, 32'h7);
    apb(1'h1, 12'h028, 32'h0);
    repeat (10) @(posedge clk);
    rdc(12'h008, 32'h7);
    apb(1'h0, 12'h028, 32'h0);
    rng(rd, 10, 20);
    gb_req <= 1'h0;
    repeat (10) @(posedge clk);
    gb_req <= 1'h1;
    repeat (3) @(posedge clk);
    apb(1'h0, 12'h028, 32'h0);
    rng(rd, 0, 11);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'h1, 12'h030, 32'h07 | m << 5);
      apb(1'h1, 12'h040, 32'hF0F);
      cap_req <= 4'h8;
      repeat (8) @(posedge clk);
      apb(1'h0, 12'h040, 32'h0);
      chk(rd[11], m[0]);
      apb(1'h1, 12'h040, 32'hF0F);
      cap_req <= 4'h0;
      repeat (8) @(posedge clk);
      apb(1'h0, 12'h040, 32'h0);
      chk(rd[11], m[1]);
      apb(1'h0, 12'h03C, 32'h0);
      rng(rd, m, m + 1);
    end
    rdc(12'h038, 32'h4);
    apb(1'h1, 12'h044, 32'h3);
    rdc(12'h044, 32'h3);
    r = 3 + int'(xs() % 8);
    apb(1'h1, 12'h024, r);
    apb(1'h1, 12'h028, 32'h0);
    apb(1'h1, 12'h034, r);
    apb(1'h1, 12'h038, 32'h0);
    apb(1'h1, 12'h020, 32'h03);
    apb(1'h1, 12'h030, 32'h13);
    l0 = lows;
    f0 = flips;
    repeat (20 * (r + 1)) @(posedge clk);
    rng(lows - l0, 19, 21);
    rng(flips - f0, 19, 21);
    report_and_stop();
  end
endmodule
